/* hdl/acs_pkg.sv */
// Purpose: constants for the converter conversion sequencer
// Assumes: byte-wide register port, one system clock
// Notes: register offsets are byte indices of the control window
`default_nettype none
package acs_pkg;
  // register offsets
  localparam logic [2:0] OFF_CHREF = 3'h0;
  localparam logic [2:0] OFF_CTLA = 3'h1;
  localparam logic [2:0] OFF_CTLB = 3'h2;
  localparam logic [2:0] OFF_RLO = 3'h3;
  localparam logic [2:0] OFF_RHI = 3'h4;
  // channel_reference_reg fields
  localparam int CH_LSB = 0;
  localparam int REF_LSB = 6;
  // converter_control_a fields
  localparam int A_PS_LSB = 0;
  localparam int A_FLAG = 4;
  localparam int A_ATE = 5;
  localparam int A_START = 6;
  localparam int A_EN = 7;
  // converter_control_b fields
  localparam int B_TS_LSB = 0;
  localparam int B_LAR = 4;
  // reset values
  localparam logic [7:0] CHREF_RST = 8'h00;
  localparam logic [7:0] CTLA_RST = 8'h00;
  localparam logic [7:0] CTLB_RST = 8'h00;
  // special channel and trigger codes
  localparam logic [5:0] CH_TEMP = 6'h22;
  localparam logic [2:0] TS_FREE = 3'h0;
  // timing in converter half cycles; SYNC_CYCLES counts system clock cycles
  localparam int HALF_NORMAL = 26;
  localparam int HALF_FIRST = 50;
  localparam int HALF_AUTO = 27;
  localparam int HALF_FREE = 28;
  localparam int SH_NORMAL = 3;
  localparam int SH_FIRST = 27;
  localparam int SH_AUTO = 4;
  localparam int SH_FREE = 5;
  localparam int SYNC_CYCLES = 3;
  // reference encodings
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [1:0] REF_EXT = 2'h1;
  localparam logic [1:0] REF_INT = 2'h2;
  typedef enum logic [1:0] {ACS_IDLE, ACS_WAIT, ACS_RUN} acs_state_e;
endpackage : acs_pkg
`default_nettype wire

/* hdl/acs_prescaler.sv */
// Purpose: power-of-two converter clock prescaler
// Assumes: one system clock, prescaler held clear while disabled
// Notes: emits one-cycle pulses at the rising and falling converter edges
`default_nettype none
module acs_prescaler #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic enable,
  input wire logic restart,
  input wire logic [2:0] ratio_select,
  output logic rise_pulse,
  output logic fall_pulse
);
  import acs_pkg::*;
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] half_mask;
  logic [WIDTH-1:0] next_count;
  // ratio 2^n, with code 0 also dividing by two; half period is 2^(n-1)
  always_comb begin
    half_mask = (ratio_select == 3'h0) ? WIDTH'(0)
              : WIDTH'((WIDTH'(1) << (ratio_select - 3'h1)) - WIDTH'(1));
    next_count = count + WIDTH'(1);
  end
  // counter runs only while enabled; restart realigns the edges [RULE16] [RULE24]
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (!enable || restart) begin
      count <= '0;
    end else if ((count & half_mask) == half_mask) begin
      count <= next_count; // low bits wrap to zero, which realigns the half period
    end else begin
      count <= next_count;
    end
  end
  // half-period tick alternates rising and falling edges
  logic phase;
  logic tick;
  assign tick = enable && !restart && ((count & half_mask) == half_mask);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase <= 1'b0;
    end else if (!enable || restart) begin
      phase <= 1'b0;
    end else if (tick) begin
      phase <= ~phase;
    end
  end
  assign rise_pulse = tick && !phase;
  assign fall_pulse = tick && phase;
endmodule // acs_prescaler
`default_nettype wire

/* hdl/acs_sequencer.sv */
// Purpose: conversion sequencing, selection latching and result readout
// Assumes: analog array presents its 10-bit code, sampled when the conversion count completes
// Notes: timing counts in converter half cycles so half-cycle points land exactly
`default_nettype none
//
// Function
// RULE1: ten-bit result, zero ground, max reference
// RULE2: two-bit reference select among three references
// RULE3: six-bit channel select, gain bit on differential
// RULE4: code 100010 selects temperature sensor
// RULE5: selections inert and converter off when disabled; gain_bypass still follows the written channel while disabled
// RULE6: right aligned default, left when bit set
// RULE7: low byte read locks until high read
// RULE8: complete flag rises even when discarded
// RULE9: start bit begins conversion, hardware clears
// RULE10: channel change waits for running conversion
// RULE11: auto trigger edge resets prescaler, starts
// RULE12: held trigger or busy edge ignored
// RULE13: software clears trigger flag before next
// RULE14: complete flag source chains conversions, first manual
// RULE15: manual start works with auto; busy reads one
// RULE16: prescaler counts only while enabled
// RULE17: start bit waits next converter rising edge
// RULE18: normal thirteen cycles, first twenty-five cycles
// RULE19: hold at 1.5, first at 13.5
// RULE20: completion writes result, sets flag, clears start
// RULE21: auto hold two cycles, total 13.5
// RULE22: free running restarts, hold 2.5, 14 cycles
// RULE23: selections latched at start, released final cycle
// RULE24: power-of-two prescaler from three-bit field
module acs_sequencer #(
  parameter int PS_WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] trigger_sources,
  input wire logic [9:0] array_code,
  output logic converter_power,
  output logic [5:0] channel_select,
  output logic [1:0] reference_select,
  output logic gain_select_bit,
  output logic gain_bypass,
  output logic temp_sensor_select,
  output logic sample_hold,
  output logic conversion_complete_flag
);
  import acs_pkg::*;
  logic [7:0] chref;
  logic [7:0] ctla;
  logic [7:0] ctlb;
  logic [7:0] result_low_byte;
  logic [7:0] result_high_byte;
  logic [5:0] sel_ch;
  logic [1:0] sel_ref;
  logic converter_enable, auto_trigger_enable, start_conversion_bit, left_align_result;
  logic [2:0] prescaler_select, trigger_source_select;
  logic read_lock, first_pending, pend_start, auto_run, free_run;
  logic [5:0] halfcnt, conv_len, sh_pt;
  logic [SYNC_CYCLES-1:0] trig_dly;
  logic trig_prev, trig_sel, trig_edge, auto_fire, ps_restart;
  logic ps_rise, ps_fall, ps_edge, done, busy;
  acs_state_e state;
  assign converter_enable = ctla[A_EN];
  assign auto_trigger_enable = ctla[A_ATE];
  assign prescaler_select = ctla[A_PS_LSB +: 3];
  assign trigger_source_select = ctlb[B_TS_LSB +: 3];
  assign left_align_result = ctlb[B_LAR];
  assign conversion_complete_flag = ctla[A_FLAG];
  assign busy = (state != ACS_IDLE);
  assign ps_edge = ps_rise || ps_fall;
  // trigger source 0 is the complete flag itself [RULE14]
  assign trig_sel = (trigger_source_select == TS_FREE) ? conversion_complete_flag
                  : trigger_sources[trigger_source_select];
  // edge seen only when idle; busy edges and held levels do nothing [RULE11] [RULE12]
  assign trig_edge = trig_sel && !trig_prev;
  assign auto_fire = trig_dly[SYNC_CYCLES-1] && !busy && converter_enable
                     && auto_trigger_enable && (trigger_source_select != TS_FREE);
  assign ps_restart = auto_fire; // [RULE11]
  assign done = (state == ACS_RUN) && ps_edge && (halfcnt == conv_len - 6'd1);
  acs_prescaler #(.WIDTH(PS_WIDTH)) u_prescaler (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(converter_enable),
    .restart(ps_restart),
    .ratio_select(prescaler_select),
    .rise_pulse(ps_rise),
    .fall_pulse(ps_fall)
  );
  // trigger edge plus three cycles of synchronisation delay [RULE21]
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trig_prev <= 1'b0;
      trig_dly <= '0;
    end else begin
      trig_prev <= trig_sel;
      trig_dly <= {trig_dly[SYNC_CYCLES-2:0], trig_edge && auto_trigger_enable && !busy}; // [RULE12]
    end
  end
  // selection register written by software, takes effect only via latch [RULE2] [RULE3]
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chref <= CHREF_RST;
    end else if (reg_write && reg_addr == OFF_CHREF) begin
      chref <= reg_wdata;
    end
  end
  // control b: trigger select and alignment
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctlb <= CTLB_RST;
    end else if (reg_write && reg_addr == OFF_CTLB) begin
      ctlb <= reg_wdata;
    end
  end
  // control a; hardware set of the flag wins over a write-one clear [RULE8] [RULE20]
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctla <= CTLA_RST;
    end else begin
      if (reg_write && reg_addr == OFF_CTLA) begin
        ctla[A_EN] <= reg_wdata[A_EN];
        ctla[A_ATE] <= reg_wdata[A_ATE];
        ctla[A_PS_LSB +: 3] <= reg_wdata[A_PS_LSB +: 3];
        if (reg_wdata[A_FLAG]) begin
          ctla[A_FLAG] <= 1'b0;
        end
      end
      if (done) begin
        ctla[A_FLAG] <= 1'b1;
      end
    end
  end
  // start request: write one, held pending until the next rising edge [RULE9] [RULE15]
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend_start <= 1'b0;
    end else if (reg_write && reg_addr == OFF_CTLA && reg_wdata[A_START]
                 && reg_wdata[A_EN] && !busy) begin
      pend_start <= 1'b1; // enable and start in one write must still start
    end else if (!converter_enable) begin
      pend_start <= 1'b0;
    end else if (state == ACS_IDLE && ps_rise) begin
      pend_start <= 1'b0; // [RULE17]
    end
  end
  // first conversion after enabling is long [RULE18]
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      first_pending <= 1'b1;
    end else if (!converter_enable) begin
      first_pending <= 1'b1;
    end else if (done) begin
      first_pending <= 1'b0;
    end
  end
  // conversion state machine
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= ACS_IDLE;
      halfcnt <= '0;
      auto_run <= 1'b0;
      free_run <= 1'b0;
    end else if (!converter_enable) begin
      state <= ACS_IDLE; // [RULE5]
      halfcnt <= '0;
      auto_run <= 1'b0;
      free_run <= 1'b0;
    end else begin
      case (state)
        ACS_IDLE: begin
          halfcnt <= '0;
          if (auto_fire) begin
            state <= ACS_RUN; // [RULE11]
            auto_run <= 1'b1;
            free_run <= 1'b0;
          end else if (pend_start && ps_rise) begin
            state <= ACS_RUN; // [RULE17]
            auto_run <= 1'b0;
            free_run <= 1'b0;
          end
        end
        ACS_WAIT: begin
          state <= ACS_IDLE;
        end
        ACS_RUN: begin
          if (ps_edge) begin
            halfcnt <= halfcnt + 6'd1;
          end
          if (done) begin
            halfcnt <= '0;
            // flag as source chains conversions regardless of clearing [RULE14] [RULE22]
            if (auto_trigger_enable && trigger_source_select == TS_FREE) begin
              free_run <= 1'b1;
              auto_run <= 1'b0;
            end else begin
              state <= ACS_IDLE; // [RULE12]
            end
          end
        end
        default: begin
          state <= ACS_IDLE;
        end
      endcase
    end
  end
  // length and hold point per conversion kind [RULE18] [RULE19] [RULE21] [RULE22]
  always_comb begin
    if (first_pending) begin
      conv_len = 6'(HALF_FIRST);
      sh_pt = 6'(SH_FIRST);
    end else if (free_run) begin
      conv_len = 6'(HALF_FREE);
      sh_pt = 6'(SH_FREE);
    end else if (auto_run) begin
      conv_len = 6'(HALF_AUTO);
      sh_pt = 6'(SH_AUTO);
    end else begin
      conv_len = 6'(HALF_NORMAL);
      sh_pt = 6'(SH_NORMAL);
    end
  end
  // hold pulse at the half-cycle point
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sample_hold <= 1'b0;
    end else begin
      sample_hold <= (state == ACS_RUN) && ps_edge && (halfcnt == sh_pt - 6'd1);
    end
  end
  // start bit reads one for any running conversion [RULE9] [RULE15] [RULE20]
  assign start_conversion_bit = busy || pend_start;
  // temporary selection tracks until start, frozen, released in last cycle [RULE10] [RULE23]
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel_ch <= CHREF_RST[CH_LSB +: 6];
      sel_ref <= CHREF_RST[REF_LSB +: 2];
    end else if (state != ACS_RUN || halfcnt >= conv_len - 6'd2) begin
      sel_ch <= chref[CH_LSB +: 6];
      sel_ref <= chref[REF_LSB +: 2];
    end
  end
  // analog controls other than gain_bypass only live while enabled [RULE5] [RULE3] [RULE4]
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      converter_power <= 1'b0;
      channel_select <= '0;
      reference_select <= REF_SUPPLY;
      gain_select_bit <= 1'b0;
      gain_bypass <= 1'b1;
      temp_sensor_select <= 1'b0;
    end else begin
      converter_power <= converter_enable;
      channel_select <= converter_enable ? sel_ch : 6'h00;
      reference_select <= converter_enable ? sel_ref : REF_SUPPLY;
      gain_select_bit <= converter_enable && !(sel_ch < 6'h08) && sel_ch[0];
      gain_bypass <= (sel_ch < 6'h08) || (sel_ch == CH_TEMP);
      temp_sensor_select <= converter_enable && (sel_ch == CH_TEMP); // [RULE4]
    end
  end
  // result bytes, aligned, blocked between low and high reads [RULE1] [RULE6] [RULE7]
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      result_low_byte <= 8'h00;
      result_high_byte <= 8'h00;
    end else if (done && !read_lock) begin
      if (left_align_result) begin
        result_high_byte <= array_code[9:2];
        result_low_byte <= {array_code[1:0], 6'h00};
      end else begin
        result_high_byte <= {6'h00, array_code[9:8]};
        result_low_byte <= array_code[7:0];
      end
    end
  end
  // lock set by low read, released by high read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      read_lock <= 1'b0;
    end else if (reg_read && reg_addr == OFF_RHI) begin
      read_lock <= 1'b0;
    end else if (reg_read && reg_addr == OFF_RLO) begin
      read_lock <= 1'b1; // [RULE7]
    end
  end
  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        OFF_CHREF: reg_rdata <= chref;
        OFF_CTLA: reg_rdata <= {ctla[7], start_conversion_bit, ctla[5:0]};
        OFF_CTLB: reg_rdata <= ctlb;
        OFF_RLO: reg_rdata <= result_low_byte;
        OFF_RHI: reg_rdata <= result_high_byte;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule // acs_sequencer
`default_nettype wire

/* tb/acs_seq_properties.sv */
// Purpose: port-level checks on the conversion sequencer
// Assumes: prescaler code 0 to 2 during conversions
// Notes: bound onto every sequencer instance
`default_nettype none
module acs_seq_properties
  import acs_pkg::*;
#(
  parameter int PS_WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] trigger_sources,
  input wire logic [9:0] array_code,
  input wire logic converter_power,
  input wire logic [5:0] channel_select,
  input wire logic [1:0] reference_select,
  input wire logic gain_select_bit,
  input wire logic gain_bypass,
  input wire logic temp_sensor_select,
  input wire logic sample_hold,
  input wire logic conversion_complete_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // control writes that switch the converter
  sequence s_en_on;
    reg_write && reg_addr == OFF_CTLA && reg_wdata[A_EN];
  endsequence
  sequence s_en_off;
    reg_write && reg_addr == OFF_CTLA && !reg_wdata[A_EN];
  endsequence
  // hold point with no stale flag left over
  sequence s_hold_fresh;
    sample_hold && !conversion_complete_flag;
  endsequence
  a_power_on_write: assert property (s_en_on |-> ##[1:2] converter_power)
    else $error("power did not follow enable");
  a_power_off_write: assert property (s_en_off |-> ##[1:2] !converter_power)
    else $error("power stayed on after disable");
  a_rdata_idle_zero: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_temp_code_match: assert property (temp_sensor_select == (channel_select == CH_TEMP))
    else $error("temperature select mismatch");
  a_hold_needs_power: assert property (sample_hold |-> converter_power)
    else $error("hold while unpowered");
  a_hold_to_flag: assert property (s_hold_fresh |-> ##[20:200] $rose(conversion_complete_flag))
    else $error("no completion after hold");
  a_select_frozen: assert property (sample_hold |=> $stable({reference_select, channel_select})[*8])
    else $error("selection moved mid conversion");
  a_flag_rise_powered: assert property ($rose(conversion_complete_flag) |-> converter_power)
    else $error("flag rose while unpowered");
endmodule // acs_seq_properties

bind acs_sequencer acs_seq_properties #(.PS_WIDTH(PS_WIDTH)) acs_seq_properties_inst (.*);
`default_nettype wire

/* tb/acs_array_model.sv */
// Purpose: behavioural successive approximation array
// Assumes: code is a fixed function of the latched selection
// Notes: unpowered code is inverted so a stale value is never trusted
`default_nettype none
module acs_array_model (
  input wire logic converter_power,
  input wire logic [5:0] channel_select,
  input wire logic [1:0] reference_select,
  output logic [9:0] array_code
);
  timeunit 1ns;
  timeprecision 100ps;
  // code built from selection, inverted while off
  assign array_code = converter_power ? {channel_select, reference_select, 2'h1}
                                      : ~{channel_select, reference_select, 2'h1};
endmodule // acs_array_model
`default_nettype wire

/* tb/acs_sequencer_bench.sv */
// Purpose: register-level tests of the conversion sequencer
// Assumes: prescaler code 0 divides by 2
// Notes: cycle windows allow for edge wait and read latency
`default_nettype none
module acs_sequencer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import acs_pkg::*;
  logic clk_sys, rst, reg_write, reg_read, converter_power, gain_select_bit, gain_bypass;
  logic temp_sensor_select, sample_hold, conversion_complete_flag;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, trigger_sources, d;
  logic [9:0] array_code;
  logic [5:0] channel_select;
  logic [1:0] reference_select;
  int cyc, error_cnt, n_tests, t0;
  acs_sequencer acs_sequencer_inst (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .trigger_sources(trigger_sources), .array_code(array_code),
    .converter_power(converter_power), .channel_select(channel_select),
    .reference_select(reference_select), .gain_select_bit(gain_select_bit),
    .gain_bypass(gain_bypass), .temp_sensor_select(temp_sensor_select),
    .sample_hold(sample_hold), .conversion_complete_flag(conversion_complete_flag));
  acs_array_model acs_array_model_inst (.converter_power(converter_power),
    .channel_select(channel_select), .reference_select(reference_select),
    .array_code(array_code));
  initial begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
  end
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // cycle count doubles as hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  // data stands in the cycle after the strobe only
  task rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task wait_idle;
    int n;
    n = 0;
    do begin
      rd(OFF_CTLA, d);
      n++;
    end while (d[A_START] !== 1'b0 && n < 500);
  endtask
  // start, then time the run until the start bit drops
  task go(input logic [7:0] v, input int lo, input int hi);
    t0 = cyc;
    wr(OFF_CTLA, v);
    wait_idle();
    n_tests++;
    if (cyc - t0 < lo || cyc - t0 > hi) begin
      error_cnt++;
      $display("CHECK FAILED duration expected %0d..%0d seen %0d", lo, hi, cyc - t0);
    end
  endtask
  initial begin
    rst = 1;
    reg_addr = 0;
    reg_wdata = 0;
    reg_write = 0;
    reg_read = 0;
    trigger_sources = 0;
    cyc = 0;
    error_cnt = 0;
    n_tests = 0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(OFF_CTLA, d); chk("ctla reset", CTLA_RST, d);
    rd(OFF_CTLB, d); chk("ctlb reset", CTLB_RST, d);
    chk("bypass reset", 8'h01, {7'h0, gain_bypass});
    // selection written while off must not reach the outputs
    wr(OFF_CHREF, {REF_INT, CH_TEMP});
    repeat (3) @(posedge clk_sys);
    chk("channel while off", 8'h00, {2'h0, channel_select});
    chk("power while off", 8'h00, {7'h0, converter_power});
    go(8'hC0, 50, 58);
    chk("channel", {2'h0, CH_TEMP}, {2'h0, channel_select});
    chk("temp select", 8'h01, {7'h0, temp_sensor_select});
    chk("reference", {6'h0, REF_INT}, {6'h0, reference_select});
    rd(OFF_CTLA, d); chk("flag after done", 8'h90, d);
    rd(OFF_RLO, d); chk("low right", 8'h29, d);
    rd(OFF_RHI, d); chk("high right", 8'h02, d);
    wr(OFF_CTLA, 8'h90);
    go(8'hC0, 26, 34);
    wr(OFF_CTLB, 8'h10);
    go(8'hC0, 26, 34);
    rd(OFF_RLO, d); chk("low left", 8'h40, d);
    rd(OFF_RHI, d); chk("high left", 8'h8A, d);
    wr(OFF_CTLB, 8'h00);
    // completion between low and high read is dropped
    rd(OFF_RLO, d); chk("low before lock", 8'h40, d);
    wr(OFF_CHREF, 8'h81);
    wr(OFF_CTLA, 8'h90);
    go(8'hC0, 26, 34);
    rd(OFF_CTLA, d); chk("flag on discard", 8'h90, d);
    rd(OFF_RHI, d); chk("high kept", 8'h8A, d);
    go(8'hC0, 26, 34);
    rd(OFF_RLO, d); chk("low new", 8'h19, d);
    rd(OFF_RHI, d); chk("high new", 8'h00, d);
    go(8'hD2, 52, 62);
    // held trigger fires once only
    wr(OFF_CTLB, 8'h01);
    wr(OFF_CTLA, 8'hB0);
    trigger_sources <= 8'h02;
    repeat (8) @(posedge clk_sys);
    rd(OFF_CTLA, d); chk("auto busy", 8'h01, {7'h0, d[A_START]});
    wait_idle();
    repeat (40) @(posedge clk_sys);
    rd(OFF_CTLA, d); chk("held trigger", 8'h00, {7'h0, d[A_START]});
    trigger_sources <= 8'h00;
    // free running keeps the start bit up past completion
    wr(OFF_CTLB, {5'h0, TS_FREE});
    wr(OFF_CTLA, 8'hB0);
    wr(OFF_CTLA, 8'hE0);
    repeat (40) @(posedge clk_sys);
    rd(OFF_CTLA, d); chk("free flag", 8'h01, {7'h0, d[A_FLAG]});
    chk("free restart", 8'h01, {7'h0, d[A_START]});
    wr(OFF_CTLA, 8'h80);
    wait_idle();
    wr(OFF_CTLA, 8'h00);
    repeat (3) @(posedge clk_sys);
    chk("power off", 8'h00, {7'h0, converter_power});
    end_sim();
  end
endmodule // acs_sequencer_bench
`default_nettype wire
